/* hdl/rtcsl_pkg.sv */
/*
 * Shared constants for the two-wire clock slave and its master end.
 * Assumes both ends run on one 50 MHz system clock.
 */
package rtcsl_pkg;
	localparam int SYS_CLK_HZ = 50000000;
	localparam int SCL_PERIOD_NS = 2500;
	localparam int SCL_HALF_CYC = (SCL_PERIOD_NS * (SYS_CLK_HZ / 1000000)) / 2000;
	localparam logic [6:0] CSS_ID_DEF = 7'h5A; // Arbitrary value.
	localparam logic [6:0] SRAM_ID_DEF = 7'h35; // Arbitrary value.
	localparam logic [7:0] ADDR_RST = 8'h00;
	localparam logic [7:0] CSS_LAST = 8'h2F;
	localparam logic [7:0] SRAM_LAST = 8'h7F;
	localparam int SRAM_DEPTH = 128;
	localparam int CSS_DEPTH = 48;
	localparam int PWRUP_CYC = 16;
	localparam logic DIR_READ = 1'b1;
	localparam logic DIR_WRITE = 1'b0;
endpackage

/* hdl/rtcsl_if.sv */
/*
 * Two-wire bus carrier between master and slave ends.
 * Resolves the open-drain wires from the enables; both pulled up.
 */
`timescale 1ns/1ps
interface rtcsl_if;
	logic scl_m_oe;
	logic sda_m_oe;
	logic sda_s_oe;
	wire logic scl;
	wire logic sda;
	// Open drain: any driver pulls low, otherwise the pull-up wins.
	assign scl = ~scl_m_oe;
	assign sda = ~(sda_m_oe | sda_s_oe);
	modport slave (input scl, input sda, output sda_s_oe);
	modport master (input scl, input sda, output scl_m_oe, output sda_m_oe);
endinterface

/* hdl/rtcsl_slave.sv */
/*
 * Two-wire slave of a real time clock: register space and 128-byte SRAM.
 * Assumes the bus lines come from outside the clock domain and are open drain.
 */
// Operation
// - Bytes move most significant bit first.
// - Data changes only while clock low.
// - Data pin released after power-up.
// - Ignore traffic until a START seen.
// - STARTs during power-up are ignored.
// - STOP ends transaction; device to standby.
// - Release after eight bits; ninth acknowledges.
// - Acknowledge identifier, word address, write data.
// - Master acknowledges read bytes wanting more.
// - Seven-bit identifier picks register space or SRAM.
// - Lowest bit one reads, zero writes.
// - Acknowledge only a matching identifier.
// - One word address byte or counter.
// - Address counter starts at zero.
// - Random read reuses same identifier.
// - Write: identifier, address, data, STOP.
// - 128 SRAM bytes via SRAM identifier.
// - Device is always the slave.
// - Keep sending while master acknowledges.
// - Register pointer wraps after 2Fh.
// - Ignore bus while on battery.
`timescale 1ns/1ps
module rtcsl_slave
	import rtcsl_pkg::*;
#(
	parameter logic [6:0] CSS_ID = CSS_ID_DEF,
	parameter logic [6:0] SRAM_ID = SRAM_ID_DEF
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rstn,
	// Power state.
	input wire logic on_battery,
	// Bus side.
	rtcsl_if.slave bus,
	// User side: last written byte.
	output logic wr_strobe_ff,
	output logic wr_space_ff,
	output logic [7:0] wr_addr_ff,
	output logic [7:0] wr_data_ff
);
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_DEVID = 6'b000010,
		ST_WADDR = 6'b000100,
		ST_WDATA = 6'b001000,
		ST_RDATA = 6'b010000,
		ST_MACK = 6'b100000
	} rtcsl_st_type;

	logic [7:0] sram_mem [SRAM_DEPTH];
	logic [7:0] css_mem [CSS_DEPTH];
	logic [1:0] scl_sync_ff, sda_sync_ff, bat_sync_ff;
	logic scl_d_ff, sda_d_ff;
	logic [4:0] pwr_cnt_ff;
	rtcsl_st_type st_ff;
	logic [2:0] bit_ff;
	logic [7:0] sh_ff;
	logic ack_ph_ff;
	logic sram_sel_ff;
	logic [7:0] ptr_ff;
	logic sda_oe_ff;
	logic [7:0] tx_ff;

	// Two-stage synchronisers; only the second stage feeds logic.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			scl_sync_ff <= 2'h3;
			sda_sync_ff <= 2'h3;
			bat_sync_ff <= 2'h0;
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_sync_ff <= {scl_sync_ff[0], bus.scl};
			sda_sync_ff <= {sda_sync_ff[0], bus.sda};
			bat_sync_ff <= {bat_sync_ff[0], on_battery};
			scl_d_ff <= scl_sync_ff[1];
			sda_d_ff <= sda_sync_ff[1];
		end
	end

	wire logic scl_s = scl_sync_ff[1];
	wire logic sda_s = sda_sync_ff[1];
	wire logic pwr_busy = (pwr_cnt_ff != 5'(PWRUP_CYC));
	wire logic active = !pwr_busy && !bat_sync_ff[1];
	wire logic start_det = active && scl_s && scl_d_ff && sda_d_ff && !sda_s;
	wire logic stop_det = scl_s && scl_d_ff && !sda_d_ff && sda_s;
	wire logic scl_rise = scl_s && !scl_d_ff;
	wire logic scl_fall = !scl_s && scl_d_ff;
	wire logic [7:0] sh_next = {sh_ff[6:0], sda_s};
	wire logic id_css = (sh_next[7:1] == CSS_ID);
	wire logic id_sram = (sh_next[7:1] == SRAM_ID);
	wire logic [7:0] ptr_inc = sram_sel_ff ? ((ptr_ff == SRAM_LAST) ? ADDR_RST : ptr_ff + 8'h01)
		: ((ptr_ff >= CSS_LAST) ? ADDR_RST : ptr_ff + 8'h01);
	wire logic [7:0] rd_byte = sram_sel_ff ? sram_mem[ptr_ff[6:0]] : css_mem[ptr_ff[5:0]];
	wire logic byte_done = scl_rise && !ack_ph_ff && (bit_ff == 3'h7);

	// Equal identifiers would make every address byte ambiguous, so they are refused.
	if (CSS_ID == SRAM_ID) begin : g_bad_id
		$error("register and SRAM identifiers must differ");
	end

	// Power-up holdoff counter.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			pwr_cnt_ff <= 5'h00;
		else if (pwr_busy)
			pwr_cnt_ff <= pwr_cnt_ff + 5'h01;
	end

	// Protocol engine: state, bit counter, shifter, pointer.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_ff <= ST_IDLE;
			bit_ff <= 3'h0;
			sh_ff <= 8'h00;
			ack_ph_ff <= 1'b0;
			sram_sel_ff <= 1'b0;
			ptr_ff <= ADDR_RST;
			wr_strobe_ff <= 1'b0;
			wr_space_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			wr_data_ff <= 8'h00;
		end else begin
			wr_strobe_ff <= 1'b0;
			if (!active && !pwr_busy) begin
				st_ff <= ST_IDLE;
			end else if (start_det) begin
				st_ff <= ST_DEVID;
				bit_ff <= 3'h0;
				ack_ph_ff <= 1'b0;
			end else if (stop_det) begin
				st_ff <= ST_IDLE;
			end else if (st_ff != ST_IDLE && scl_rise) begin
				if (ack_ph_ff) begin
					ack_ph_ff <= 1'b0;
					bit_ff <= 3'h0;
					if (st_ff == ST_MACK) begin
						if (!sda_s)
							st_ff <= ST_RDATA;
						else
							st_ff <= ST_IDLE;
					end
				end else begin
					sh_ff <= sh_next;
					bit_ff <= bit_ff + 3'h1;
					if (bit_ff == 3'h7) begin
						ack_ph_ff <= 1'b1;
						case (st_ff)
							ST_DEVID: begin
								if (id_css || id_sram) begin
									sram_sel_ff <= id_sram;
									st_ff <= (sh_next[0] == DIR_READ) ? ST_RDATA : ST_WADDR;
								end else begin
									st_ff <= ST_IDLE;
								end
							end
							ST_WADDR: begin
								ptr_ff <= sh_next;
								st_ff <= ST_WDATA;
							end
							ST_WDATA: begin
								wr_strobe_ff <= 1'b1;
								wr_space_ff <= sram_sel_ff;
								wr_addr_ff <= ptr_ff;
								wr_data_ff <= sh_next;
								ptr_ff <= ptr_inc;
							end
							ST_RDATA: begin
								ptr_ff <= ptr_inc;
								st_ff <= ST_MACK;
							end
							default: st_ff <= ST_IDLE;
						endcase
					end
				end
			end
		end
	end

	// Memories written on each accepted write byte; register space only up to 2Fh.
	always_ff @(posedge clk_sys) begin
		if (st_ff == ST_WDATA && byte_done) begin
			if (sram_sel_ff)
				sram_mem[ptr_ff[6:0]] <= sh_next;
			else if (ptr_ff <= CSS_LAST)
				css_mem[ptr_ff[5:0]] <= sh_next;
		end
	end

	// Read shifter, loaded at byte start, so the pointer may advance before the byte has left.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			tx_ff <= 8'hFF;
		else if ((st_ff == ST_RDATA) && (bit_ff == 3'h0) && !ack_ph_ff && scl_fall)
			tx_ff <= rd_byte;
		else if ((st_ff == ST_RDATA) && scl_fall && !ack_ph_ff)
			tx_ff <= {tx_ff[6:0], 1'b1};
	end

	// Data pin drive set only on falling clock edges; released at once on START, STOP, idle or inactive.
	wire logic ack_drive = ack_ph_ff && (st_ff == ST_WADDR || st_ff == ST_WDATA || st_ff == ST_RDATA);
	wire logic rd_drive = (st_ff == ST_RDATA) && !ack_ph_ff;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			sda_oe_ff <= 1'b0;
		else if (!active || start_det || stop_det || st_ff == ST_IDLE)
			sda_oe_ff <= 1'b0;
		else if (scl_fall)
			sda_oe_ff <= ack_drive ? 1'b1 : (rd_drive && bit_ff == 3'h0) ? !rd_byte[7]
				: rd_drive ? !tx_ff[6] : 1'b0;
	end

	assign bus.sda_s_oe = sda_oe_ff;
endmodule // rtcsl_slave

/* hdl/rtcsl_master.sv */
/*
 * Two-wire master end: one write or one current-address read byte per request.
 * Assumes an open-drain bus with pull-ups provided by the carrier.
 */
`timescale 1ns/1ps
module rtcsl_master
	import rtcsl_pkg::*;
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rstn,
	// Request side.
	input wire logic req_valid,
	input wire logic [6:0] req_id,
	input wire logic req_dir,
	input wire logic [7:0] req_addr,
	input wire logic [7:0] req_data,
	output logic req_ready_ff,
	// Answer side.
	output logic rsp_valid_ff,
	output logic [7:0] rsp_data_ff,
	output logic rsp_nack_ff,
	// Bus side.
	rtcsl_if.master bus
);
	typedef enum logic [3:0] {
		MS_IDLE = 4'b0001,
		MS_START = 4'b0010,
		MS_BITS = 4'b0100,
		MS_STOP = 4'b1000
	} rtcsl_mst_type;

	rtcsl_mst_type st_ff;
	logic dir_ff;
	logic [23:0] buf_mem [2];
	logic buf_wp_ff, buf_rp_ff;
	logic [1:0] buf_cnt_ff;
	logic [15:0] div_ff;
	logic [1:0] ph_ff;
	logic [1:0] sda_sync_ff;
	logic [5:0] idx_ff;
	logic [26:0] seq_ff;
	logic [7:0] rx_ff;
	logic scl_oe_ff, sda_oe_ff, nack_ff;

	wire logic tick = (div_ff == 16'(SCL_HALF_CYC / 2 - 1));
	wire logic sda_s = sda_sync_ff[1];
	wire logic [5:0] last_idx = 6'h1A;
	wire logic ack_slot = (idx_ff == 6'h08) || (idx_ff == 6'h11) || (idx_ff == 6'h1A);
	wire logic rd_slot = dir_ff && (idx_ff >= 6'h09) && (idx_ff <= 6'h10);

	// Request buffer: two entries, so a request offered while the engine is busy is never dropped.
	wire logic buf_push = req_valid && req_ready_ff;
	wire logic eng_valid = (buf_cnt_ff != 2'h0);
	wire logic eng_ready = (st_ff == MS_IDLE);
	wire logic buf_pop = eng_valid && eng_ready;
	wire logic [1:0] nxt_buf_cnt = buf_cnt_ff + {1'b0, buf_push} - {1'b0, buf_pop};
	wire logic [23:0] buf_head = buf_mem[buf_rp_ff];
	wire logic [6:0] head_id = buf_head[23:17];
	wire logic head_dir = buf_head[16];
	wire logic [7:0] head_addr = buf_head[15:8];
	wire logic [7:0] head_data = buf_head[7:0];

	// Buffer pointers and occupancy; ready is registered from the next occupancy.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			buf_wp_ff <= 1'b0;
			buf_rp_ff <= 1'b0;
			buf_cnt_ff <= 2'h0;
			req_ready_ff <= 1'b0;
		end else begin
			buf_cnt_ff <= nxt_buf_cnt;
			req_ready_ff <= (nxt_buf_cnt != 2'h2);
			if (buf_push)
				buf_wp_ff <= !buf_wp_ff;
			if (buf_pop)
				buf_rp_ff <= !buf_rp_ff;
		end
	end

	// Buffer storage needs no reset; an entry is only read while it is counted.
	always_ff @(posedge clk_sys) begin
		if (buf_push)
			buf_mem[buf_wp_ff] <= {req_id, req_dir, req_addr, req_data};
	end

	// Divider for quarter-period enables.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			div_ff <= 16'h0000;
			sda_sync_ff <= 2'h3;
		end else begin
			div_ff <= tick ? 16'h0000 : div_ff + 16'h0001;
			sda_sync_ff <= {sda_sync_ff[0], bus.sda};
		end
	end

	// Bit sequencer: each bit spans four phases, data set while clock low.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_ff <= MS_IDLE;
			ph_ff <= 2'h0;
			idx_ff <= 6'h00;
			seq_ff <= 27'h0;
			rx_ff <= 8'h00;
			scl_oe_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
			nack_ff <= 1'b0;
			dir_ff <= 1'b0;
			rsp_valid_ff <= 1'b0;
			rsp_data_ff <= 8'h00;
			rsp_nack_ff <= 1'b0;
		end else begin
			rsp_valid_ff <= 1'b0;
			if (buf_pop) begin
				st_ff <= MS_START;
				ph_ff <= 2'h0;
				nack_ff <= 1'b0;
				dir_ff <= head_dir;
				// Read: id, eight released bits, master no-ack; write: id, address, data.
				seq_ff <= head_dir ? {head_id, DIR_READ, 1'b1, 8'hFF, 1'b1, 9'h1FF}
					: {head_id, DIR_WRITE, 1'b1, head_addr, 1'b1, head_data, 1'b1};
			end else if (tick) begin
				ph_ff <= ph_ff + 2'h1;
				case (st_ff)
					MS_START: begin
						if (ph_ff == 2'h1)
							sda_oe_ff <= 1'b1;
						if (ph_ff == 2'h3) begin
							scl_oe_ff <= 1'b1;
							idx_ff <= 6'h00;
							st_ff <= MS_BITS;
						end
					end
					MS_BITS: begin
						if (ph_ff == 2'h0)
							sda_oe_ff <= !seq_ff[26];
						if (ph_ff == 2'h1)
							scl_oe_ff <= 1'b0;
						if (ph_ff == 2'h2) begin
							if (ack_slot && sda_s && idx_ff <= (dir_ff ? 6'h08 : last_idx))
								nack_ff <= 1'b1;
							if (rd_slot)
								rx_ff <= {rx_ff[6:0], sda_s};
						end
						if (ph_ff == 2'h3) begin
							scl_oe_ff <= 1'b1;
							seq_ff <= {seq_ff[25:0], 1'b1};
							idx_ff <= idx_ff + 6'h01;
							if (idx_ff == (dir_ff ? 6'h11 : last_idx) || nack_ff)
								st_ff <= MS_STOP;
						end
					end
					MS_STOP: begin
						if (ph_ff == 2'h0)
							sda_oe_ff <= 1'b1;
						if (ph_ff == 2'h1)
							scl_oe_ff <= 1'b0;
						if (ph_ff == 2'h3) begin
							sda_oe_ff <= 1'b0;
							st_ff <= MS_IDLE;
							rsp_valid_ff <= 1'b1;
							rsp_data_ff <= rx_ff;
							rsp_nack_ff <= nack_ff;
						end
					end
					default: st_ff <= MS_IDLE;
				endcase
			end
		end
	end

	assign bus.scl_m_oe = scl_oe_ff;
	assign bus.sda_m_oe = sda_oe_ff;
endmodule // rtcsl_master

/* sim/rtcsl_sva.sv */
/*
 * Checker of the two-wire bus between the master and slave ends.
 * Assumes it watches the resolved wires and the enables of one carrier.
 */
`timescale 1ns/1ps
module rtcsl_sva (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rstn,
	// Bus wires and enables.
	input wire logic scl,
	input wire logic sda,
	input wire logic scl_m_oe,
	input wire logic sda_m_oe,
	input wire logic sda_s_oe
);
	logic scl_q_ff;
	logic sda_q_ff;
	logic [3:0] bit_cnt_ff;
	// Counts clock rises since START, saturating, so the address byte can be located.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			scl_q_ff <= 1'b1;
			sda_q_ff <= 1'b1;
			bit_cnt_ff <= 4'h0;
		end else begin
			scl_q_ff <= scl;
			sda_q_ff <= sda;
			if (scl && scl_q_ff && sda_q_ff && !sda) begin
				bit_cnt_ff <= 4'h0;
			end else if (scl && !scl_q_ff && bit_cnt_ff != 4'hF) begin
				bit_cnt_ff <= bit_cnt_ff + 4'h1;
			end
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	hold_off_a: assert property ($rose(rstn) |-> !sda_s_oe [*8])
		else $error("slave drove data right after reset");
	addr_quiet_a: assert property (bit_cnt_ff < 4'h8 |-> !sda_s_oe)
		else $error("slave drove data inside the address byte");
	low_change_a: assert property ($changed(sda_s_oe) |-> !scl)
		else $error("slave data changed while clock high");
	ack_stand_a: assert property ($rose(sda_s_oe) |-> sda_s_oe [*8])
		else $error("slave drive too short");
	start_quiet_a: assert property (scl && $fell(sda) |=> !sda_s_oe [*4])
		else $error("slave drove data at START");
	stop_quiet_a: assert property (scl && $rose(sda) |-> ##1 !sda_s_oe [*8])
		else $error("slave drove data after STOP");
	scl_high_a: assert property ($rose(scl) |-> scl [*8])
		else $error("clock high phase too short");
	scl_low_a: assert property ($rose(scl_m_oe) |-> scl_m_oe [*8])
		else $error("clock low phase too short");
	// Main scenarios: address acknowledge, later slave drive, master START and STOP.
	cover property (bit_cnt_ff == 4'h8 && sda_s_oe);
	cover property ($rose(sda_s_oe) && bit_cnt_ff > 4'h8);
	cover property (scl && $rose(sda_m_oe));
	cover property (scl && $rose(sda));
endmodule // rtcsl_sva

/* sim/tb.sv */
/*
 * Bench joining master and slave ends: writes, wrapped reads, refusals.
 * Assumes the package identifiers and the carrier pull-ups.
 */
`timescale 1ns/1ps
module tb;
	import rtcsl_pkg::*;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic on_battery = 1'b0;
	logic req_valid = 1'b0;
	logic [6:0] req_id = 7'h00;
	logic req_dir = 1'b0;
	logic [7:0] req_addr = 8'h00;
	logic [7:0] req_data = 8'h00;
	logic req_ready_ff, rsp_valid_ff, rsp_nack_ff, wr_strobe_ff, wr_space_ff;
	logic [7:0] rsp_data_ff, wr_addr_ff, wr_data_ff;
	logic [7:0] n_wr = 8'h00;
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;
	rtcsl_if bus_if ();
	rtcsl_master rtcsl_master_i (.clk_sys(clk_sys), .rstn(rstn), .req_valid(req_valid), .req_id(req_id),
		.req_dir(req_dir), .req_addr(req_addr), .req_data(req_data), .req_ready_ff(req_ready_ff),
		.rsp_valid_ff(rsp_valid_ff), .rsp_data_ff(rsp_data_ff), .rsp_nack_ff(rsp_nack_ff), .bus(bus_if));
	rtcsl_slave rtcsl_slave_i (.clk_sys(clk_sys), .rstn(rstn), .on_battery(on_battery), .bus(bus_if),
		.wr_strobe_ff(wr_strobe_ff), .wr_space_ff(wr_space_ff), .wr_addr_ff(wr_addr_ff), .wr_data_ff(wr_data_ff));
	rtcsl_sva rtcsl_sva_i (.clk_sys(clk_sys), .rstn(rstn), .scl(bus_if.scl), .sda(bus_if.sda),
		.scl_m_oe(bus_if.scl_m_oe), .sda_m_oe(bus_if.sda_m_oe), .sda_s_oe(bus_if.sda_s_oe));
	// System clock at 50 MHz.
	initial begin
		forever #10 clk_sys = ~clk_sys;
	end
	// Counts accepted write bytes; a hang is cut short well past the planned run.
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (wr_strobe_ff === 1'b1) begin
			n_wr <= n_wr + 8'h01;
		end
		if (cyc == 60000) begin
			err_count++;
			final_report();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Valid is offered for one edge while ready is high; the payload stays until the answer.
	task automatic txn(input logic [6:0] id, input logic dir, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		while (req_ready_ff !== 1'b1) begin
			@(negedge clk_sys);
		end
		@(posedge clk_sys);
		req_id <= id;
		req_dir <= dir;
		req_addr <= a;
		req_data <= d;
		req_valid <= 1'b1;
		@(posedge clk_sys);
		req_valid <= 1'b0;
		while (rsp_valid_ff !== 1'b1) begin
			@(negedge clk_sys);
		end
	endtask
	task automatic wr_ok(input logic [6:0] id, input logic [7:0] a, input logic [7:0] d, input logic sp);
		logic [7:0] n0;
		n0 = n_wr;
		txn(id, DIR_WRITE, a, d);
		chk({7'h00, rsp_nack_ff}, 8'h00);
		chk(n_wr, n0 + 8'h01);
		chk(wr_addr_ff, a);
		chk(wr_data_ff, d);
		chk({7'h00, wr_space_ff}, {7'h00, sp});
	endtask
	// Write pointer wrap, then read pointer wrap; each read reuses the writing identifier.
	task automatic sc_css_wrap();
		wr_ok(CSS_ID_DEF, ADDR_RST, 8'h5E, 1'b0);
		wr_ok(CSS_ID_DEF, CSS_LAST, 8'h77, 1'b0);
		txn(CSS_ID_DEF, DIR_READ, 8'h00, 8'h00);
		chk({7'h00, rsp_nack_ff}, 8'h00);
		chk(rsp_data_ff, 8'h5E);
		wr_ok(CSS_ID_DEF, CSS_LAST - 8'h01, 8'h66, 1'b0);
		txn(CSS_ID_DEF, DIR_READ, 8'h00, 8'h00);
		chk(rsp_data_ff, 8'h77);
		txn(CSS_ID_DEF, DIR_READ, 8'h00, 8'h00);
		chk(rsp_data_ff, 8'h5E);
	endtask
	task automatic sc_sram();
		wr_ok(SRAM_ID_DEF, 8'h00, 8'hC3, 1'b1);
		wr_ok(SRAM_ID_DEF, SRAM_LAST, 8'h3C, 1'b1);
		txn(SRAM_ID_DEF, DIR_READ, 8'h00, 8'h00);
		chk(rsp_data_ff, 8'hC3);
	endtask
	// A reset in mid-run returns the pointer to zero; the SRAM write to zero left the register byte alone.
	task automatic sc_reset();
		@(posedge clk_sys);
		rstn <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rstn <= 1'b1;
		txn(CSS_ID_DEF, DIR_READ, 8'h00, 8'h00);
		chk(rsp_data_ff, 8'h5E);
	endtask
	// A refused request must leave the slave free for the next START.
	task automatic sc_refuse();
		logic [7:0] n0;
		n0 = n_wr;
		txn(7'h11, DIR_WRITE, 8'h01, 8'h99);
		chk({7'h00, rsp_nack_ff}, 8'h01);
		@(posedge clk_sys);
		on_battery <= 1'b1;
		txn(CSS_ID_DEF, DIR_WRITE, 8'h01, 8'h99);
		chk({7'h00, rsp_nack_ff}, 8'h01);
		@(posedge clk_sys);
		on_battery <= 1'b0;
		chk(n_wr, n0);
		wr_ok(SRAM_ID_DEF, 8'h10, 8'hA5, 1'b1);
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Reset for 20 cycles, then the scenarios in turn.
	initial begin
		repeat (20) @(posedge clk_sys);
		rstn <= 1'b1;
		sc_css_wrap();
		sc_sram();
		sc_reset();
		sc_refuse();
		final_report();
	end
endmodule // tb
